/* design/rmc_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the radio modem controller.
// Assumes: A 100 MHz system clock.
// Notes:   Definitions only; included by the package.
`ifndef RMC_MAP_SVH
`define RMC_MAP_SVH

// ----------------------------------------------------------------------------
// APB register offsets and fields
// ----------------------------------------------------------------------------
`define RMC_OFS_CTRL      12'h000
`define RMC_OFS_STATUS    12'h004
`define RMC_CTRL_ACK_BIT  0
`define RMC_STAT_CFG_BIT  0
`define RMC_STAT_BUSY_BIT 1
`define RMC_STAT_CNT_LSB  8

// ----------------------------------------------------------------------------
// Factory settings
// ----------------------------------------------------------------------------
`define RMC_DEF_ADDR      24'h7F7F7F
`define RMC_DEF_CHAN      8'h02
`define RMC_DEF_POWER     8'h07
`define RMC_DEF_RATE      8'h01
`define RMC_HW_VERSION    8'h01
`define RMC_FW_VERSION    8'h01

// ----------------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------------
`define RMC_BUF_BYTES     55
`define RMC_MAX_RETRY     10
`define RMC_CLK_NS        10
`define RMC_FLUSH_MS      10
`define RMC_GUARD_MS      1
`define RMC_ACKWAIT_MS    2
`define RMC_PING_S        1
`define RMC_FLUSH_CYC     (`RMC_FLUSH_MS * 1000000 / `RMC_CLK_NS)
`define RMC_GUARD_CYC     (`RMC_GUARD_MS * 1000000 / `RMC_CLK_NS)
`define RMC_ACKWAIT_CYC   (`RMC_ACKWAIT_MS * 1000000 / `RMC_CLK_NS)
`define RMC_PING_CYC      (`RMC_PING_S * 1000000000 / `RMC_CLK_NS)

// ----------------------------------------------------------------------------
// ASCII characters
// ----------------------------------------------------------------------------
`define RMC_CH_CR         8'h0D
`define RMC_CH_PLUS       8'h2B
`define RMC_CH_SPACE      8'h20
`define RMC_CH_QUERY      8'h3F
`define RMC_CH_F          8'h46
`define RMC_CH_H          8'h48
`define RMC_CH_P          8'h50
`define RMC_CH_S          8'h53
`define RMC_CH_Q          8'h51
`define RMC_CH_V          8'h56

`endif

/* design/rmc_pkg.sv */
// Purpose: Types shared by the radio modem controller and its surroundings.
// Assumes: rmc_map.svh holds every number.
// Notes:   Structs carry the byte, radio and APB groups.
`include "rmc_map.svh"

package rmc_pkg;

	// Main controller states.
	typedef enum logic [2:0] {
		RMC_ON   = 3'b000,
		RMC_TX   = 3'b001,
		RMC_WAIT = 3'b010,
		RMC_CFG  = 3'b011,
		RMC_PING = 3'b100
	} rmc_state_t;

	// Radio packet kinds.
	typedef enum logic [1:0] {
		RMC_K_DATA = 2'b00,
		RMC_K_ACK  = 2'b01,
		RMC_K_PING = 2'b10,
		RMC_K_PONG = 2'b11
	} rmc_kind_t;

	// Text replies.
	typedef enum logic [2:0] {
		RMC_M_DUMP  = 3'b000,
		RMC_M_OK    = 3'b001,
		RMC_M_SAVED = 3'b010,
		RMC_M_HELP  = 3'b011,
		RMC_M_VER   = 3'b100,
		RMC_M_PONG  = 3'b101
	} rmc_msg_t;

	// One serial byte with its valid.
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} rmc_byte_t;

	// One radio beat, outgoing.
	typedef struct packed {
		logic       valid;
		rmc_kind_t  kind;
		logic [23:0] addr;
		logic [23:0] src;
		logic [7:0] id;
		logic [7:0] data;
		logic       last;
	} rmc_rf_tx_t;

	// One radio beat, incoming, with its signal strength.
	typedef struct packed {
		logic       valid;
		rmc_kind_t  kind;
		logic [23:0] addr;
		logic [23:0] src;
		logic [7:0] id;
		logic [7:0] data;
		logic       last;
		logic [7:0] rssi;
	} rmc_rf_rx_t;

	// Modem settings.
	typedef struct packed {
		logic [23:0] dest;
		logic [23:0] own;
		logic [7:0]  chan;
		logic [7:0]  power;
		logic [7:0]  rate;
		logic        ack;
	} rmc_cfg_t;

	// APB request and answer.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} rmc_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} rmc_apb_rsp_t;

	localparam rmc_cfg_t RMC_CFG_DEF = '{dest: `RMC_DEF_ADDR, own: `RMC_DEF_ADDR,
		chan: `RMC_DEF_CHAN, power: `RMC_DEF_POWER, rate: `RMC_DEF_RATE, ack: 1'b0};

endpackage

/* design/rmc_modem_ctrl.sv */
// Purpose: Host-side controller of a serial radio modem: online data path and command mode.
// Assumes: Serial bytes arrive already framed (8N1) and synchronous to i_sys_clk.
// Notes:   All state lives in one struct registered by a single clocked process.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module rmc_modem_ctrl import rmc_pkg::*; #(
	parameter int unsigned DEPTH       = `RMC_BUF_BYTES,
	parameter int unsigned MAX_RETRY   = `RMC_MAX_RETRY,
	parameter int unsigned FLUSH_CYC   = `RMC_FLUSH_CYC,
	parameter int unsigned GUARD_CYC   = `RMC_GUARD_CYC,
	parameter int unsigned ACKWAIT_CYC = `RMC_ACKWAIT_CYC,
	parameter int unsigned PING_CYC    = `RMC_PING_CYC
) (
	// Clock and reset.
	input  wire logic         i_sys_clk,
	input  wire logic         i_sys_rst,
	// Host serial byte stream and flow control.
	input  wire rmc_byte_t    i_host_rx,
	input  wire logic         i_rts_n,
	input  wire logic         i_host_tx_ready,
	output var  rmc_byte_t    o_host_tx,
	output var  logic         o_cts_n,
	// Radio packet beats.
	output var  rmc_rf_tx_t   o_rf_tx,
	input  wire logic         i_rf_tx_ready,
	input  wire rmc_rf_rx_t   i_rf_rx,
	output var  logic         o_rf_rx_ready,
	// Register bus.
	input  wire rmc_apb_req_t i_apb,
	output var  rmc_apb_rsp_t o_apb,
	// Mode indicator.
	output var  logic         o_config_mode
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

	// Whole block state; one copy is registered, the other is its next value.
	typedef struct packed {
		rmc_state_t            fsm;        // Main mode and phase.
		rmc_cfg_t              cfg;        // Live settings.
		rmc_cfg_t              saved;      // Settings kept by the save command.
		logic [DEPTH-1:0][7:0] buffer;     // Serial bytes waiting for the radio.
		logic [CW-1:0]         cnt;        // Bytes held.
		logic [CW-1:0]         idx;        // Next byte to send.
		logic [31:0]           idle;       // Cycles since the last online host byte or quit command.
		logic [1:0]            plus;       // Pluses seen in a row.
		logic [31:0]           timer;      // Ack wait or ping period.
		logic [3:0]            retry;      // Resends of the current packet.
		logic [7:0]            pkt_id;     // Rolling packet identifier.
		logic [7:0]            cmd;        // Command letter being collected.
		logic [1:0]            cmd_n;      // 0 none, 1 one letter, 2 too many.
		logic                  rep_busy;   // A text reply is being sent.
		rmc_msg_t              msg;        // Which reply.
		logic [4:0]            ridx;       // Character within the reply.
		logic                  pend_v;     // A single-beat answer waits to go out.
		rmc_kind_t             pend_kind;  // Its kind.
		logic [23:0]           pend_addr;  // Its destination.
		logic [7:0]            pend_id;    // Its identifier.
		logic [7:0]            pend_data;  // Its payload byte.
		logic [23:0]           pong_src;   // Last ping answer address.
		logic [7:0]            pong_rssi;  // Last ping answer strength.
		rmc_byte_t             host_tx;    // Byte offered to the host.
		logic                  cts_n;      // Clear-to-send, active low.
		rmc_rf_tx_t            rf_tx;      // Beat offered to the radio.
		logic                  rf_rx_rdy;  // Radio receive acceptance.
		rmc_apb_rsp_t          apb;        // Bus answer.
	} st_t;

	st_t s_ff;   // Registered state.
	st_t nxt_s;  // Next state.

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------

	// Nibble to upper-case ASCII hex.
	function automatic logic [7:0] hex_ch(input logic [3:0] n);
		hex_ch = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

	// Character i of reply m; bit 8 marks the last character.
	function automatic logic [8:0] msg_char(input rmc_msg_t m, input logic [4:0] i,
		input rmc_cfg_t c, input logic [23:0] a, input logic [7:0] r);
		logic [7:0] t [0:31];
		logic [4:0] n;
		for (int k = 0; k < 32; k++) begin
			t[k] = `RMC_CH_SPACE;
		end
		n = 5'h00;
		unique case (m)
			RMC_M_DUMP: begin
				for (int k = 0; k < 6; k++) begin
					t[k]     = hex_ch(c.dest[23-4*k -: 4]);
					t[k + 7] = hex_ch(c.own[23-4*k -: 4]);
				end
				t[6]  = `RMC_CH_CR;
				t[13] = `RMC_CH_CR;
				t[14] = hex_ch(c.chan[7:4]);
				t[15] = hex_ch(c.chan[3:0]);
				t[16] = `RMC_CH_CR;
				t[17] = hex_ch(c.power[7:4]);
				t[18] = hex_ch(c.power[3:0]);
				t[19] = `RMC_CH_CR;
				t[20] = hex_ch(c.rate[7:4]);
				t[21] = hex_ch(c.rate[3:0]);
				t[22] = `RMC_CH_CR;
				t[23] = 8'h30;
				t[24] = hex_ch({3'h0, c.ack});
				t[25] = `RMC_CH_CR;
				n = 5'd25;
			end
			RMC_M_OK: begin
				t[0] = 8'h4F;
				t[1] = 8'h4B;
				t[2] = `RMC_CH_CR;
				n = 5'd2;
			end
			RMC_M_SAVED: begin
				t[0] = `RMC_CH_S;
				t[1] = 8'h41;
				t[2] = `RMC_CH_V;
				t[3] = 8'h45;
				t[4] = 8'h44;
				t[5] = `RMC_CH_CR;
				n = 5'd5;
			end
			RMC_M_HELP: begin
				t[0]  = `RMC_CH_QUERY;
				t[2]  = `RMC_CH_F;
				t[4]  = `RMC_CH_H;
				t[6]  = `RMC_CH_P;
				t[8]  = `RMC_CH_S;
				t[10] = `RMC_CH_Q;
				t[12] = `RMC_CH_V;
				t[13] = `RMC_CH_CR;
				n = 5'd13;
			end
			RMC_M_VER: begin
				t[0] = `RMC_CH_H;
				t[1] = hex_ch(4'(`RMC_HW_VERSION >> 4));
				t[2] = hex_ch(4'(`RMC_HW_VERSION));
				t[4] = `RMC_CH_F;
				t[5] = hex_ch(4'(`RMC_FW_VERSION >> 4));
				t[6] = hex_ch(4'(`RMC_FW_VERSION));
				t[7] = `RMC_CH_CR;
				n = 5'd7;
			end
			default: begin  // Ping answer report.
				for (int k = 0; k < 6; k++) begin
					t[k] = hex_ch(a[23-4*k -: 4]);
				end
				if (c.dest == c.own) begin
					t[7]  = 8'h28;
					t[8]  = hex_ch(r[7:4]);
					t[9]  = hex_ch(r[3:0]);
					t[10] = 8'h29;
					t[11] = `RMC_CH_CR;
					n = 5'd11;
				end else begin
					t[6] = `RMC_CH_CR;
					n = 5'd6;
				end
			end
		endcase
		msg_char = {(i == n), t[i]};
	endfunction

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------

	// Every behaviour is decided here from the registered state and the inputs.
	always_comb begin
		logic       htx_free;
		logic       tx_free;
		logic       rx_take;
		logic       online;
		logic [8:0] mc;
		nxt_s = s_ff;
		// A byte leaves when the host is ready and asserts its request to send.
		htx_free = !s_ff.host_tx.valid || (i_host_tx_ready && !i_rts_n);
		tx_free  = !s_ff.rf_tx.valid || i_rf_tx_ready;
		rx_take  = i_rf_rx.valid && s_ff.rf_rx_rdy;
		online   = (s_ff.fsm == RMC_ON) || (s_ff.fsm == RMC_TX) || (s_ff.fsm == RMC_WAIT);
		mc       = msg_char(s_ff.msg, s_ff.ridx, s_ff.cfg, s_ff.pong_src, s_ff.pong_rssi);
		if (htx_free) begin
			nxt_s.host_tx.valid = 1'b0;
		end
		if (tx_free) begin
			nxt_s.rf_tx.valid = 1'b0;
		end
		if (s_ff.idle != 32'hFFFF_FFFF) begin
			nxt_s.idle = s_ff.idle + 32'd1;
		end

		// Radio receive: only addressed traffic, and only while online.
		if (rx_take && online && (i_rf_rx.addr == s_ff.cfg.own)) begin
			unique case (i_rf_rx.kind)
				RMC_K_DATA: begin
					nxt_s.host_tx = '{valid: 1'b1, data: i_rf_rx.data};
					if (s_ff.cfg.ack && i_rf_rx.last) begin
						nxt_s.pend_v    = 1'b1;
						nxt_s.pend_kind = RMC_K_ACK;
						nxt_s.pend_addr = i_rf_rx.src;
						nxt_s.pend_id   = i_rf_rx.id;
					end
				end
				RMC_K_PING: begin
					nxt_s.pend_v    = 1'b1;
					nxt_s.pend_kind = RMC_K_PONG;
					nxt_s.pend_addr = i_rf_rx.src;
					nxt_s.pend_data = i_rf_rx.rssi;
				end
				RMC_K_ACK: begin
					// Matching acknowledgement ends the wait.
					if ((s_ff.fsm == RMC_WAIT) && (i_rf_rx.id == s_ff.pkt_id)) begin
						nxt_s.fsm    = RMC_ON;
						nxt_s.cnt    = '0;
						nxt_s.retry  = 4'h0;
						nxt_s.pkt_id = s_ff.pkt_id + 8'h01;
					end
				end
				RMC_K_PONG: begin
				end
			endcase
		end

		unique case (s_ff.fsm)
			RMC_ON: begin
				if (i_host_rx.valid) begin
					nxt_s.idle = 32'd0;
					// Bytes beyond the buffer size are dropped.
					if (s_ff.cnt < DEPTH_C) begin
						nxt_s.buffer[s_ff.cnt] = i_host_rx.data;
						nxt_s.cnt = s_ff.cnt + 1'b1;
					end
					// Escape counting: first plus needs a quiet line before it.
					if (i_host_rx.data != `RMC_CH_PLUS || s_ff.plus == 2'd3) begin
						nxt_s.plus = 2'd0;
					end else if (s_ff.plus != 2'd0 || s_ff.idle >= GUARD_CYC) begin
						nxt_s.plus = s_ff.plus + 2'd1;
					end
				end else if (s_ff.plus == 2'd3 && s_ff.idle >= GUARD_CYC) begin
					// Three isolated pluses and a quiet line after them.
					nxt_s.fsm      = RMC_CFG;
					nxt_s.cnt      = '0;
					nxt_s.plus     = 2'd0;
					nxt_s.cmd_n    = 2'd0;
					nxt_s.pend_v   = 1'b0;
					nxt_s.rep_busy = 1'b1;
					nxt_s.msg      = RMC_M_DUMP;
					nxt_s.ridx     = 5'd0;
				end else if (s_ff.pend_v && tx_free) begin
					// Answers to other nodes go ahead of our own data.
					nxt_s.rf_tx  = '{valid: 1'b1, kind: s_ff.pend_kind, addr: s_ff.pend_addr,
						src: s_ff.cfg.own, id: s_ff.pend_id, data: s_ff.pend_data, last: 1'b1};
					nxt_s.pend_v = 1'b0;
				end else if (s_ff.cnt != '0 && (s_ff.idle >= FLUSH_CYC || s_ff.cnt == DEPTH_C)
					&& s_ff.plus == 2'd0) begin
					// Quiet line or full buffer: send what is held.
					nxt_s.fsm   = RMC_TX;
					nxt_s.idx   = '0;
					nxt_s.retry = 4'h0;
				end
			end
			RMC_TX: begin
				// Incoming bytes are lost while a packet is out; CTS holds the host off.
				if (i_host_rx.valid) begin
					nxt_s.idle = 32'd0;
				end
				if (tx_free) begin
					nxt_s.rf_tx = '{valid: 1'b1, kind: RMC_K_DATA, addr: s_ff.cfg.dest,
						src: s_ff.cfg.own, id: s_ff.pkt_id, data: s_ff.buffer[s_ff.idx],
						last: (s_ff.idx == s_ff.cnt - 1'b1)};
					nxt_s.idx = s_ff.idx + 1'b1;
					if (s_ff.idx == s_ff.cnt - 1'b1) begin
						nxt_s.timer = 32'd0;
						if (s_ff.cfg.ack) begin
							nxt_s.fsm = RMC_WAIT;
						end else begin
							nxt_s.fsm    = RMC_ON;
							nxt_s.cnt    = '0;
							nxt_s.pkt_id = s_ff.pkt_id + 8'h01;
						end
					end
				end
			end
			RMC_WAIT: begin
				if (i_host_rx.valid) begin
					nxt_s.idle = 32'd0;
				end
				nxt_s.timer = s_ff.timer + 32'd1;
				// No matching acknowledgement in time: resend, up to the limit.
				if (s_ff.timer >= ACKWAIT_CYC && nxt_s.fsm == RMC_WAIT) begin
					if (s_ff.retry < 4'(MAX_RETRY)) begin
						nxt_s.retry = s_ff.retry + 4'h1;
						nxt_s.idx   = '0;
						nxt_s.fsm   = RMC_TX;
					end else begin
						nxt_s.fsm    = RMC_ON;
						nxt_s.cnt    = '0;
						nxt_s.pkt_id = s_ff.pkt_id + 8'h01;
					end
				end
			end
			RMC_CFG: begin
				// Offline: radio stays silent and received beats are discarded.
				if (i_host_rx.valid) begin
					if (i_host_rx.data == `RMC_CH_CR) begin
						nxt_s.cmd_n = 2'd0;
						if (s_ff.cmd_n == 2'd1 && !s_ff.rep_busy) begin
							nxt_s.ridx = 5'd0;
							// Only upper-case letters and the question mark match.
							unique case (s_ff.cmd)
								`RMC_CH_QUERY: begin
									nxt_s.rep_busy = 1'b1;
									nxt_s.msg      = RMC_M_DUMP;
								end
								`RMC_CH_F: begin
									nxt_s.cfg      = RMC_CFG_DEF;
									nxt_s.cfg.ack  = s_ff.cfg.ack;
									nxt_s.rep_busy = 1'b1;
									nxt_s.msg      = RMC_M_OK;
								end
								`RMC_CH_H: begin
									nxt_s.rep_busy = 1'b1;
									nxt_s.msg      = RMC_M_HELP;
								end
								`RMC_CH_P: begin
									nxt_s.fsm   = RMC_PING;
									nxt_s.timer = PING_CYC;
								end
								`RMC_CH_S: begin
									nxt_s.saved    = s_ff.cfg;
									nxt_s.rep_busy = 1'b1;
									nxt_s.msg      = RMC_M_SAVED;
								end
								`RMC_CH_Q: begin
									nxt_s.fsm  = RMC_ON;
									nxt_s.idle = 32'd0;
								end
								`RMC_CH_V: begin
									nxt_s.rep_busy = 1'b1;
									nxt_s.msg      = RMC_M_VER;
								end
								default: begin
								end
							endcase
						end
					end else begin
						nxt_s.cmd   = i_host_rx.data;
						nxt_s.cmd_n = (s_ff.cmd_n == 2'd0) ? 2'd1 : 2'd2;
					end
				end
			end
			default: begin  // RMC_PING
				nxt_s.timer = s_ff.timer + 32'd1;
				if (i_host_rx.valid) begin  // Any character stops pinging.
					nxt_s.fsm   = RMC_CFG;
					nxt_s.cmd_n = 2'd0;
				end else if (s_ff.timer >= PING_CYC && tx_free) begin
					nxt_s.rf_tx = '{valid: 1'b1, kind: RMC_K_PING, addr: s_ff.cfg.dest,
						src: s_ff.cfg.own, id: s_ff.pkt_id, data: 8'h00, last: 1'b1};
					nxt_s.timer = 32'd0;
				end
				if (rx_take && i_rf_rx.kind == RMC_K_PONG && i_rf_rx.addr == s_ff.cfg.own
					&& !s_ff.rep_busy) begin
					nxt_s.pong_src  = i_rf_rx.src;
					nxt_s.pong_rssi = i_rf_rx.data;
					nxt_s.rep_busy  = 1'b1;
					nxt_s.msg       = RMC_M_PONG;
					nxt_s.ridx      = 5'd0;
				end
			end
		endcase

		// Text replies go out one character at a time.
		if (s_ff.rep_busy && htx_free) begin
			nxt_s.host_tx = '{valid: 1'b1, data: mc[7:0]};
			nxt_s.ridx    = s_ff.ridx + 5'd1;
			if (mc[8]) begin
				nxt_s.rep_busy = 1'b0;
			end
		end

		// Flow control toward the host: hold off while sending or nearly full.
		// The last data beat still counts as sending until the radio takes it.
		nxt_s.cts_n = (nxt_s.fsm == RMC_TX) || (nxt_s.fsm == RMC_WAIT)
			|| (nxt_s.rf_tx.valid && nxt_s.rf_tx.kind == RMC_K_DATA)
			|| (nxt_s.cnt >= DEPTH_C - 1'b1);
		// Radio beats are taken always in command mode, while pinging when no reply is out, and otherwise only when a forwarded byte has room.
		nxt_s.rf_rx_rdy = (nxt_s.fsm == RMC_CFG) || (nxt_s.fsm == RMC_PING && !nxt_s.rep_busy)
			|| (!nxt_s.host_tx.valid && !nxt_s.pend_v);

		// APB slave: one wait state, then pready with data.
		nxt_s.apb = '{pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0};
		if (i_apb.psel && i_apb.penable && !s_ff.apb.pready) begin
			nxt_s.apb.pready = 1'b1;
			unique case (i_apb.paddr)
				`RMC_OFS_CTRL: begin
					nxt_s.apb.prdata[`RMC_CTRL_ACK_BIT] = s_ff.cfg.ack;
				end
				`RMC_OFS_STATUS: begin
					nxt_s.apb.prdata[`RMC_STAT_CFG_BIT]  = (s_ff.fsm == RMC_CFG)
						|| (s_ff.fsm == RMC_PING);
					nxt_s.apb.prdata[`RMC_STAT_BUSY_BIT] = (s_ff.fsm == RMC_TX)
						|| (s_ff.fsm == RMC_WAIT);
					nxt_s.apb.prdata[`RMC_STAT_CNT_LSB +: CW] = s_ff.cnt;
				end
				default: begin
					nxt_s.apb.pslverr = 1'b1;
				end
			endcase
		end
		// The write lands at the edge where the master sees pready.
		if (i_apb.psel && i_apb.penable && s_ff.apb.pready && i_apb.pwrite
			&& i_apb.paddr == `RMC_OFS_CTRL) begin
			nxt_s.cfg.ack = i_apb.pwdata[`RMC_CTRL_ACK_BIT];
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------

	// Reset loads factory settings; everything else starts at zero.
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s_ff       <= '0;
			s_ff.cfg   <= RMC_CFG_DEF;
			s_ff.saved <= RMC_CFG_DEF;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs come straight from the state register, except o_config_mode, which is decoded from fsm.
	assign o_host_tx     = s_ff.host_tx;
	assign o_cts_n       = s_ff.cts_n;
	assign o_rf_tx       = s_ff.rf_tx;
	assign o_rf_rx_ready = s_ff.rf_rx_rdy;
	assign o_apb         = s_ff.apb;
	assign o_config_mode = (s_ff.fsm == RMC_CFG) || (s_ff.fsm == RMC_PING);

endmodule

`default_nettype wire

/* tb/rmc_modem_ctrl_properties.sv */
// Purpose: Port assertions of the modem controller.
// Assumes: Own address stays at the factory value.
// Notes:   Bound to every controller instance.
`timescale 1ns/1ns
`default_nettype none
module rmc_modem_ctrl_properties import rmc_pkg::*; (
	// Watched ports.
	input wire logic         i_sys_clk,
	input wire logic         i_sys_rst,
	input wire rmc_apb_req_t i_apb,
	input wire rmc_apb_rsp_t o_apb,
	input wire rmc_byte_t    o_host_tx,
	input wire logic         i_host_tx_ready,
	input wire logic         i_rts_n,
	input wire logic         o_cts_n,
	input wire rmc_rf_tx_t   o_rf_tx,
	input wire logic         i_rf_tx_ready,
	input wire rmc_rf_rx_t   i_rf_rx,
	input wire logic         o_rf_rx_ready,
	input wire logic         o_config_mode
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	// An access phase the slave has not answered yet.
	sequence s_take;
		i_apb.psel && i_apb.penable && !o_apb.pready;
	endsequence
	// A radio beat taken online that is meant for another node.
	sequence s_foreign;
		i_rf_rx.valid && o_rf_rx_ready && !o_config_mode && i_rf_rx.addr != RMC_CFG_DEF.own;
	endsequence
	a_apb_answer: assert property (s_take |=> o_apb.pready) else $error("apb no answer");
	a_apb_unmap: assert property (s_take ##0 (i_apb.paddr > 12'h004) |=>
		o_apb.pslverr && o_apb.prdata == 32'h0) else $error("apb unmapped");
	a_pready_one: assert property (o_apb.pready |=> !o_apb.pready) else $error("pready");
	a_cfg_no_data: assert property (o_config_mode |->
		!(o_rf_tx.valid && o_rf_tx.kind == RMC_K_DATA)) else $error("rf in config");
	a_rf_hold: assert property (o_rf_tx.valid && !i_rf_tx_ready |=>
		$stable(o_rf_tx)) else $error("rf beat moved");
	a_host_hold: assert property (o_host_tx.valid && !(i_host_tx_ready && !i_rts_n) |=>
		$stable(o_host_tx)) else $error("host byte moved");
	a_cts_busy: assert property (o_rf_tx.valid && o_rf_tx.kind == RMC_K_DATA |->
		o_cts_n) else $error("cts low in send");
	a_src_own: assert property (o_rf_tx.valid |-> o_rf_tx.src == RMC_CFG_DEF.own)
		else $error("bad source");
	a_rx_foreign: assert property (s_foreign |=> !$rose(o_host_tx.valid))
		else $error("foreign data");
endmodule
bind rmc_modem_ctrl rmc_modem_ctrl_properties u_props (.i_sys_clk, .i_sys_rst, .i_apb,
	.o_apb, .o_host_tx, .i_host_tx_ready, .i_rts_n, .o_cts_n, .o_rf_tx, .i_rf_tx_ready,
	.i_rf_rx, .o_rf_rx_ready, .o_config_mode);
`default_nettype wire

/* tb/rmc_host_model.sv */
// Purpose: Host controller on the serial side.
// Assumes: Bytes arrive framed, one per handshake.
// Notes:   Ready toggles every cycle, so it is a slow taker.
`timescale 1ns/1ns
`default_nettype none
module rmc_host_model import rmc_pkg::*; (
	input  wire logic      i_sys_clk,
	input  wire rmc_byte_t i_byte,
	output logic           o_ready = 1'b0,
	output logic           o_rts_n
);
	logic [7:0] got[$]; // Bytes the host has taken.
	// RTS tied low is permitted; ready alone paces bytes toward the host.
	assign o_rts_n = 1'b0;
	// Half-rate taker exercises the hold of the byte.
	always @(posedge i_sys_clk) begin
		if (i_byte.valid && o_ready && !o_rts_n) got.push_back(i_byte.data);
		o_ready <= ~o_ready;
	end
endmodule
`default_nettype wire

/* tb/rmc_modem_ctrl_tb.sv */
// Purpose: Self-checking bench of the modem controller.
// Assumes: Shortened counts; the radio side never acknowledges.
// Notes:   Host side is the host model.
`timescale 1ns/1ns
`default_nettype none
module rmc_modem_ctrl_tb import rmc_pkg::*;;
	localparam int FLUSH = 50;
	localparam int GUARD = 20;
	localparam int HOLDOFF = FLUSH * 3 / 2;
	logic i_sys_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic rf_ok = 1'b0;
	logic cts_n, rx_rdy, cfg_mode, tx_rdy, rts_n;
	rmc_byte_t host_rx = '0;
	rmc_byte_t host_tx;
	rmc_rf_rx_t rf_rx = '0;
	rmc_rf_tx_t rf_tx;
	rmc_apb_req_t apb = '0;
	rmc_apb_rsp_t apb_rsp;
	int error_cnt = 0, total_checks = 0, beats = 0, cycles = 0, pings = 0;
	logic [7:0] last_id, last_data;
	logic [7:0] cmd [5] = '{8'h3F, 8'h46, 8'h48, 8'h53, 8'h56};
	logic [7:0] first [5] = '{8'h37, 8'h4F, 8'h3F, 8'h53, 8'h48};
	rmc_modem_ctrl #(.FLUSH_CYC(FLUSH), .GUARD_CYC(GUARD), .ACKWAIT_CYC(30), .PING_CYC(100))
	i_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_host_rx(host_rx), .i_rts_n(rts_n),
		.i_host_tx_ready(tx_rdy), .o_host_tx(host_tx), .o_cts_n(cts_n), .o_rf_tx(rf_tx),
		.i_rf_tx_ready(rf_ok), .i_rf_rx(rf_rx), .o_rf_rx_ready(rx_rdy), .i_apb(apb),
		.o_apb(apb_rsp), .o_config_mode(cfg_mode));
	rmc_host_model host (.i_sys_clk(i_sys_clk), .i_byte(host_tx), .o_ready(tx_rdy),
		.o_rts_n(rts_n));
	always #5 i_sys_clk = ~i_sys_clk;
	// Radio stalls every other cycle; finished data packets are counted.
	always @(posedge i_sys_clk) begin
		rf_ok <= ~rf_ok;
		cycles <= cycles + 1;
		if (rf_ok && rf_tx.valid && rf_tx.kind == RMC_K_PING) pings <= pings + 1;
		if (cycles == 6000) begin
			error_cnt++;
			give_verdict();
		end
		if (rf_ok && rf_tx.valid && rf_tx.kind == RMC_K_DATA && rf_tx.last) begin
			beats <= beats + 1;
			last_id <= rf_tx.id;
			last_data <= rf_tx.data;
		end
	end
	task give_verdict();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge i_sys_clk);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge i_sys_clk);
		apb.penable <= 1'b1;
		do @(posedge i_sys_clk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb <= '0;
	endtask
	task send(input logic [7:0] b);
		@(posedge i_sys_clk);
		host_rx <= '{valid: 1'b1, data: b};
		@(posedge i_sys_clk);
		host_rx <= ~host_rx;
	endtask
	task rx_beat(input rmc_kind_t k, input logic [23:0] a, input logic [7:0] b);
		@(posedge i_sys_clk);
		rf_rx <= '{1'b1, k, a, 24'h123456, 8'h05, b, 1'b1, 8'h80};
		do @(posedge i_sys_clk); while (rx_rdy !== 1'b1);
		rf_rx <= ~rf_rx;
	endtask
	task t_online();
		int b0;
		b0 = beats;
		send(8'h41);
		repeat (FLUSH - 5) @(posedge i_sys_clk);
		chk(beats - b0, 0);
		repeat (30) @(posedge i_sys_clk);
		chk(beats - b0, 1);
		chk(last_data, 8'h41);
	endtask
	task t_retry();
		logic [31:0] rd;
		logic e;
		int b0;
		logic [7:0] id0;
		apb_xfer(1'b1, 12'h000, 32'h1, rd, e);
		apb_xfer(1'b0, 12'h000, 32'h0, rd, e);
		chk(rd, 32'h1);
		apb_xfer(1'b0, 12'h010, 32'h0, rd, e);
		chk({31'h0, e}, 32'h1);
		id0 = last_id;
		b0 = beats;
		repeat (HOLDOFF) @(posedge i_sys_clk);
		send(8'h42);
		repeat (70) @(posedge i_sys_clk);
		chk(cts_n, 1);
		repeat (830) @(posedge i_sys_clk);
		chk(beats - b0, 11);
		chk(last_id != id0, 1);
		apb_xfer(1'b1, 12'h000, 32'h0, rd, e);
	endtask
	task t_rx();
		int n;
		n = host.got.size();
		rx_beat(RMC_K_DATA, RMC_CFG_DEF.own, 8'h5A);
		rx_beat(RMC_K_DATA, 24'h123456, 8'h33);
		repeat (20) @(posedge i_sys_clk);
		chk(host.got.size() - n, 1);
		chk(host.got[n], 8'h5A);
	endtask
	task t_cfg();
		int n;
		int p;
		repeat (GUARD + 5) @(posedge i_sys_clk);
		repeat (3) send(8'h2B);
		repeat (GUARD + 5) @(posedge i_sys_clk);
		chk(cfg_mode, 1);
		repeat (200) @(posedge i_sys_clk);
		n = host.got.size();
		send(8'h76);
		send(8'h0D);
		repeat (40) @(posedge i_sys_clk);
		chk(host.got.size() - n, 0);
		foreach (cmd[i]) begin
			n = host.got.size();
			send(cmd[i]);
			send(8'h0D);
			repeat (200) @(posedge i_sys_clk);
			chk(host.got[n], first[i]);
		end
		n = host.got.size();
		p = pings;
		send(8'h50);
		send(8'h0D);
		repeat (150) @(posedge i_sys_clk);
		chk(pings - p, 2);
		rx_beat(RMC_K_PONG, RMC_CFG_DEF.own, 8'hD5);
		repeat (60) @(posedge i_sys_clk);
		chk(host.got.size() - n, 12);
		chk(host.got[n + 8], 8'h44);
		send(8'h2E);
		p = pings;
		repeat (120) @(posedge i_sys_clk);
		chk(pings - p, 0);
		n = host.got.size();
		send(8'h51);
		send(8'h0D);
		repeat (20) @(posedge i_sys_clk);
		chk(cfg_mode, 0);
		chk(host.got.size() - n, 0);
	endtask
	initial begin
		repeat (20) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		t_online();
		t_retry();
		t_rx();
		t_cfg();
		give_verdict();
	end
endmodule
`default_nettype wire
